// ### scip_defines.vh
// constants for the smbus configuration port
`ifndef SCIP_DEFINES_VH
`define SCIP_DEFINES_VH
`define SCIP_CLK_MHZ        125
`define SCIP_REF_LOSS_NS    1000
`define SCIP_REF_LOSS_CYC   ((`SCIP_REF_LOSS_NS * `SCIP_CLK_MHZ) / 1000)
`define SCIP_REG_OUT_EN     8'h00
`define SCIP_PAIR1_BIT      5
`define SCIP_PAIR0_BIT      3
`define SCIP_OUT_EN_RST     8'hff
`define SCIP_OUT_EN_RSVD    8'hd7
`define SCIP_UNMAPPED_RD    8'h00
`define SCIP_READ_COUNT     8'h08
`define SCIP_ADDR_SEL0      7'h50
`define SCIP_ADDR_SEL1      7'h51
`endif

// ### scip_pair_buf.v
// two-entry buffer between byte receiver and register file
`timescale 1ns/1ps
`default_nettype none
module scip_pair_buf #(
   parameter WIDTH = 16
) (
   input  wire             core_clk_in,
   input  wire             rstn_in,
   input  wire             in_valid_in,
   output wire             in_ready_out,
   input  wire [WIDTH-1:0] in_data_in,
   output wire             out_valid_out,
   input  wire             out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);
   reg [WIDTH-1:0] mem [0:1];
   reg             wr_ptr;
   reg             rd_ptr;
   reg [1:0]       count;
   wire            push;
   wire            pop;

   assign in_ready_out  = (count != 2'd2);
   assign out_valid_out = (count != 2'd0);
   assign out_data_out  = mem[rd_ptr];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'd0;
         mem[0] <= {WIDTH{1'b0}};
         mem[1] <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data_in;
            wr_ptr      <= ~wr_ptr;
         end
         if (pop)
            rd_ptr <= ~rd_ptr;
         if (push && !pop)
            count <= count + 2'd1;
         else if (pop && !push)
            count <= count - 2'd1;
      end
   end
endmodule // scip_pair_buf
`default_nettype wire

// ### scip_smbus_port.v
// smbus target with indexed block access and output-pair enable byte
// Operation
// - device acknowledges the starting index byte after its address
// - byte count follows index and is acknowledged, then data bytes until stop, count value unused
// - each written data byte is acknowledged and stored while the buffer has room, index advances
// - device sends the byte count first after read address acknowledge
// - register bytes follow from index n onward, one at a time
// - target address comes from select pin latched once after reset
// - byte 0 bit 5 enables pair 1, reset one
// - byte 0 bit 3 enables pair 0, reset one
// - cleared software enable overrides hardware enable pin, pair low
// - port answers only while the reference clock runs
`timescale 1ns/1ps
`default_nettype none
`include "scip_defines.vh"
module scip_smbus_port #(
   parameter REF_LOSS_CYC = `SCIP_REF_LOSS_CYC
) (
   input  wire       core_clk_in,
   input  wire       rstn_in,
   input  wire       scl_in,
   input  wire       sda_in,
   output wire       sda_out,
   output wire       sda_oe_out,
   input  wire       target_address_select_pin_in,
   input  wire       ref_clk_in,
   input  wire       pair0_hw_enable_n_in,
   input  wire       pair1_hw_enable_n_in,
   output reg        pair0_run_out,
   output reg        pair1_run_out,
   output reg        ref_running_out
);
   localparam ST_IDLE  = 3'd0;
   localparam ST_ADDR  = 3'd1;
   localparam ST_INDEX = 3'd2;
   localparam ST_COUNT = 3'd3;
   localparam ST_WDATA = 3'd4;
   localparam ST_ACK   = 3'd5;
   localparam ST_TX    = 3'd6;
   localparam ST_RACK  = 3'd7;
   localparam [7:0] EN_RST = `SCIP_OUT_EN_RST;

   reg [1:0]  scl_sync;
   reg [1:0]  sda_sync;
   reg [1:0]  ref_sync;
   reg [1:0]  sel_sync;
   reg [1:0]  hw0_sync;
   reg [1:0]  hw1_sync;
   reg        scl_d;
   reg        sda_d;
   reg        ref_d;
   reg [15:0] ref_cnt;
   reg [1:0]  lat_cnt;
   reg [6:0]  target_addr;
   reg [2:0]  state;
   reg [2:0]  after_ack;
   reg [3:0]  bit_cnt;
   reg [7:0]  shreg;
   reg [7:0]  index;
   reg        send_count;
   reg        host_ack;
   reg        pair0_sw_enable;
   reg        pair1_sw_enable;

   wire       scl_s = scl_sync[1];
   wire       sda_s = sda_sync[1];
   wire       scl_rise = scl_s & ~scl_d;
   wire       scl_fall = ~scl_s & scl_d;
   wire       bus_start = scl_s & scl_d & sda_d & ~sda_s;
   wire       bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
   wire       rd_fetch;
   wire       buf_in_ready;
   wire       buf_valid;
   wire       wr_push;
   wire [15:0] buf_data;

   function [7:0] reg_read;
      input [7:0] idx;
      input       en0;
      input       en1;
      begin
         reg_read = `SCIP_UNMAPPED_RD;
         if (idx == `SCIP_REG_OUT_EN) begin
            reg_read = `SCIP_OUT_EN_RSVD;
            reg_read[`SCIP_PAIR1_BIT] = en1;
            reg_read[`SCIP_PAIR0_BIT] = en0;
         end
      end
   endfunction

   // only the open-drain low is ever driven
   assign sda_out    = 1'b0;
   assign sda_oe_out = (state == ST_ACK) | ((state == ST_TX) & ~shreg[7]);
   assign rd_fetch   = scl_fall & (((state == ST_ACK) & (after_ack == ST_TX))
                       | ((state == ST_RACK) & host_ack));
   assign wr_push    = scl_fall & (state == ST_WDATA) & (bit_cnt == 4'd8)
                       & buf_in_ready;

   // pins cross into core clock through two flops
   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
         ref_sync <= 2'b00;
         sel_sync <= 2'b00;
         hw0_sync <= 2'b11;
         hw1_sync <= 2'b11;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
         ref_d    <= 1'b0;
      end else begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         ref_sync <= {ref_sync[0], ref_clk_in};
         sel_sync <= {sel_sync[0], target_address_select_pin_in};
         hw0_sync <= {hw0_sync[0], pair0_hw_enable_n_in};
         hw1_sync <= {hw1_sync[0], pair1_hw_enable_n_in};
         scl_d    <= scl_s;
         sda_d    <= sda_s;
         ref_d    <= ref_sync[1];
      end
   end

   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ref_cnt         <= 16'h0000;
         ref_running_out <= 1'b0;
      end else if (ref_sync[1] != ref_d) begin
         ref_cnt         <= 16'h0000;
         ref_running_out <= 1'b1;
      end else if (ref_cnt >= REF_LOSS_CYC[15:0]) begin
         ref_running_out <= 1'b0;
      end else begin
         ref_cnt <= ref_cnt + 16'h0001;
      end
   end

   // latch select once, pin changes later ignored
   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         lat_cnt     <= 2'd0;
         target_addr <= `SCIP_ADDR_SEL0;
      end else if (lat_cnt != 2'd3) begin
         lat_cnt <= lat_cnt + 2'd1;
         if (lat_cnt == 2'd2)
            target_addr <= sel_sync[1] ? `SCIP_ADDR_SEL1 : `SCIP_ADDR_SEL0;
      end
   end

   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state      <= ST_IDLE;
         after_ack  <= ST_IDLE;
         bit_cnt    <= 4'd0;
         shreg      <= 8'hff;
         index      <= 8'h00;
         send_count <= 1'b0;
         host_ack   <= 1'b0;
      end else if (!ref_running_out || bus_stop) begin
         state <= ST_IDLE;
      end else if (bus_start) begin
         state   <= ST_ADDR;
         bit_cnt <= 4'd0;
      end else begin
         case (state)
         ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA: begin
            if (scl_rise && bit_cnt != 4'd8) begin
               shreg   <= {shreg[6:0], sda_s};
               bit_cnt <= bit_cnt + 4'd1;
            end else if (scl_fall && bit_cnt == 4'd8) begin
               bit_cnt <= 4'd0;
               state   <= ST_ACK;
               if (state == ST_ADDR) begin
                  if (shreg[7:1] != target_addr)
                     state <= ST_IDLE;
                  else if (shreg[0]) begin
                     after_ack  <= ST_TX;
                     send_count <= 1'b1;
                  end else
                     after_ack <= ST_INDEX;
               end else if (state == ST_INDEX) begin
                  index     <= shreg;
                  after_ack <= ST_COUNT;
               end else if (state == ST_COUNT) begin
                  after_ack <= ST_WDATA;
               end else begin
                  after_ack <= ST_WDATA;
                  index     <= index + 8'h01;
                  if (!buf_in_ready)
                     state <= ST_IDLE;
               end
            end
         end
         ST_ACK: begin
            if (scl_fall) begin
               state <= after_ack;
               if (after_ack == ST_TX) begin
                  send_count <= 1'b0;
                  // count first, then bytes from n
                  if (send_count)
                     shreg <= `SCIP_READ_COUNT;
                  else begin
                     shreg <= reg_read(index, pair0_sw_enable,
                                       pair1_sw_enable);
                     index <= index + 8'h01;
                  end
               end
            end
         end
         ST_TX: begin
            if (scl_fall) begin
               if (bit_cnt == 4'd7) begin
                  bit_cnt <= 4'd0;
                  shreg   <= 8'hff;
                  state   <= ST_RACK;
               end else begin
                  bit_cnt <= bit_cnt + 4'd1;
                  shreg   <= {shreg[6:0], 1'b1};
               end
            end
         end
         ST_RACK: begin
            if (scl_rise)
               host_ack <= ~sda_s;
            else if (scl_fall) begin
               if (host_ack) begin
                  state <= ST_TX;
                  shreg <= reg_read(index, pair0_sw_enable, pair1_sw_enable);
                  index <= index + 8'h01;
               end else
                  state <= ST_IDLE;
            end
         end
         default: state <= ST_IDLE;
         endcase
      end
   end

   // a full buffer turns the data acknowledge into a nack
   scip_pair_buf #(
      .WIDTH (16)
   ) u_buf (
      .core_clk_in   (core_clk_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (wr_push),
      .in_ready_out  (buf_in_ready),
      .in_data_in    ({index, shreg}),
      .out_valid_out (buf_valid),
      .out_ready_in  (~rd_fetch),
      .out_data_out  (buf_data)
   );

   // drain stalls on read fetch cycles to keep reads coherent
   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pair0_sw_enable <= EN_RST[`SCIP_PAIR0_BIT];
         pair1_sw_enable <= EN_RST[`SCIP_PAIR1_BIT];
      end else if (buf_valid && !rd_fetch
                   && buf_data[15:8] == `SCIP_REG_OUT_EN) begin
         pair1_sw_enable <= buf_data[`SCIP_PAIR1_BIT];
         pair0_sw_enable <= buf_data[`SCIP_PAIR0_BIT];
      end
   end

   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pair0_run_out <= 1'b0;
         pair1_run_out <= 1'b0;
      end else begin
         pair0_run_out <= pair0_sw_enable & ~hw0_sync[1];
         pair1_run_out <= pair1_sw_enable & ~hw1_sync[1];
      end
   end
endmodule // scip_smbus_port
`default_nettype wire

// ### scip_smbus_port_monitor.sv
// assertions on the smbus configuration port pins
`timescale 1ns/1ps
`default_nettype none
module scip_smbus_port_monitor #(
   parameter int REF_LOSS_CYC = 125
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic target_address_select_pin_in,
   input wire logic ref_clk_in,
   input wire logic pair0_hw_enable_n_in,
   input wire logic pair1_hw_enable_n_in,
   input wire logic pair0_run_out,
   input wire logic pair1_run_out,
   input wire logic ref_running_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   logic [9:0] idle;
   logic       ref_q;
   // cycles since the reference last changed, saturating
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         idle  <= 10'h000;
         ref_q <= 1'b0;
      end else begin
         ref_q <= ref_clk_in;
         if (ref_q != ref_clk_in) idle <= 10'h000;
         else if (idle != 10'h3ff) idle <= idle + 10'h001;
      end
   end
   chk_oe_no_ref: assert property (
      !ref_running_out [*2] |-> !sda_oe_out) else $error("drive, no ref");
   chk_ref_lost: assert property (
      idle > REF_LOSS_CYC + 8 |-> !ref_running_out) else $error("ref lost");
   chk_ref_back: assert property (
      $rose(ref_running_out) |-> idle < 10'h00a) else $error("ref rise");
   chk_oe_rise_low: assert property (
      $rose(sda_oe_out) |-> !scl_in) else $error("pull in scl high");
   chk_oe_fall_low: assert property (
      $fell(sda_oe_out) |-> !scl_in) else $error("release in scl high");
   chk_oe_hold_high: assert property (
      scl_in && $past(scl_in) |-> $stable(sda_oe_out))
      else $error("sda moved in scl high");
   chk_pair0_pin: assert property (
      pair0_hw_enable_n_in [*5] |-> !pair0_run_out) else $error("pair0 on");
   chk_pair1_pin: assert property (
      pair1_hw_enable_n_in [*5] |-> !pair1_run_out) else $error("pair1 on");
   chk_sda_drive_low: assert property (
      sda_out == 1'b0) else $error("sda driven high");
endmodule // scip_smbus_port_monitor
bind scip_smbus_port scip_smbus_port_monitor #(
   .REF_LOSS_CYC(REF_LOSS_CYC)
) i_scip_smbus_port_monitor (
   .core_clk_in, .rstn_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
   .target_address_select_pin_in, .ref_clk_in, .pair0_hw_enable_n_in,
   .pair1_hw_enable_n_in, .pair0_run_out, .pair1_run_out, .ref_running_out
);
`default_nettype wire

// ### scip_smbus_host.sv
// smbus host model with bit and byte tasks
`timescale 1ns/1ps
`default_nettype none
module scip_smbus_host (
   input  wire logic core_clk_in,
   input  wire logic sda_in,
   output var logic  scl_out,
   output var logic  sda_pull_out
);
   // quarter bit above the port's 3-cycle sync lag, 160 ns per bit
   localparam int QTR = 5;
   initial begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
   end
   task automatic tick();
      repeat (QTR) @(posedge core_clk_in);
      #1;
   endtask
   task automatic start();
      sda_pull_out = 1'b0;
      tick();
      scl_out = 1'b1;
      tick();
      sda_pull_out = 1'b1;
      tick();
      scl_out = 1'b0;
      tick();
   endtask
   task automatic stop();
      sda_pull_out = 1'b1;
      tick();
      scl_out = 1'b1;
      tick();
      sda_pull_out = 1'b0;
      tick();
   endtask
   // data only moves while scl is low
   task automatic xbit(input logic b, output logic r);
      sda_pull_out = ~b;
      tick();
      scl_out = 1'b1;
      tick();
      r = sda_in;
      tick();
      scl_out = 1'b0;
      tick();
   endtask
   task automatic xbyte(input logic [7:0] d, input logic k,
                        output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
      xbit(k, a);
   endtask
endmodule // scip_smbus_host
`default_nettype wire

// ### scip_smbus_port_tb_top.sv
// bench for the smbus configuration port
`timescale 1ns/1ps
`default_nettype none
`include "scip_defines.vh"
module scip_smbus_port_tb_top;
   localparam logic [7:0] P0 = 8'h01 << `SCIP_PAIR0_BIT;
   localparam logic [7:0] P1 = 8'h01 << `SCIP_PAIR1_BIT;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       ref_clk = 1'b0;
   logic       ref_en = 1'b1;
   logic       strap = 1'b0;
   logic       hw0_n = 1'b0;
   logic       hw1_n = 1'b0;
   logic [6:0] dev = `SCIP_ADDR_SEL0;
   logic [7:0] cnt, b0, b1;
   logic       a;
   wire        scl, pull, oe, p0, p1, ref_ok;
   wire        sda = ~pull & ~oe;
   int         err_total = 0;
   int         compares = 0;
   int         cyc = 0;
   always #4 clk = ~clk;
   // free-running reference, edges 1 ns after a core edge
   initial begin
      #37;
      forever #80 if (ref_en) ref_clk = ~ref_clk;
   end
   scip_smbus_port i_scip_smbus_port (
      .core_clk_in(clk), .rstn_in(rst_n), .scl_in(scl), .sda_in(sda),
      .sda_out(), .sda_oe_out(oe), .target_address_select_pin_in(strap),
      .ref_clk_in(ref_clk), .pair0_hw_enable_n_in(hw0_n),
      .pair1_hw_enable_n_in(hw1_n), .pair0_run_out(p0),
      .pair1_run_out(p1), .ref_running_out(ref_ok));
   scip_smbus_host i_scip_smbus_host (
      .core_clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic ack(input logic e);
      chk({7'h00, a}, {7'h00, e});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic e, input logic [7:0] d0,
                     input logic [7:0] d1, input int n);
      logic [7:0] r;
      i_scip_smbus_host.start();
      i_scip_smbus_host.xbyte({dev, 1'b0}, 1'b1, r, a);
      ack(e);
      if (e === 1'b0) begin
         i_scip_smbus_host.xbyte(8'h00, 1'b1, r, a);
         ack(1'b0);
         i_scip_smbus_host.xbyte(n[7:0], 1'b1, r, a);
         ack(1'b0);
         i_scip_smbus_host.xbyte(d0, 1'b1, r, a);
         ack(1'b0);
         if (n > 1) i_scip_smbus_host.xbyte(d1, 1'b1, r, a);
         if (n > 1) ack(1'b0);
      end
      i_scip_smbus_host.stop();
   endtask
   task automatic rd(input logic [7:0] ix, input int n);
      logic [7:0] r;
      i_scip_smbus_host.start();
      i_scip_smbus_host.xbyte({dev, 1'b0}, 1'b1, r, a);
      ack(1'b0);
      i_scip_smbus_host.xbyte(ix, 1'b1, r, a);
      ack(1'b0);
      i_scip_smbus_host.start();
      i_scip_smbus_host.xbyte({dev, 1'b1}, 1'b1, r, a);
      ack(1'b0);
      i_scip_smbus_host.xbyte(8'hff, 1'b0, cnt, a);
      i_scip_smbus_host.xbyte(8'hff, n == 1, b0, a);
      if (n > 1) i_scip_smbus_host.xbyte(8'hff, 1'b1, b1, a);
      i_scip_smbus_host.stop();
      chk(cnt, `SCIP_READ_COUNT);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         $display("FAIL %0t timeout", $time);
         end_sim();
      end
   end
   initial begin
      wt(2);
      rst_n = 1'b1;
      wt(60);
      chk({6'h00, p1, p0}, 8'h03);
      rd(8'h00, 2);
      chk(b0, `SCIP_OUT_EN_RST);
      chk(b1, `SCIP_UNMAPPED_RD);
      $display("test reset values done");
      wr(1'b0, 8'h00, 8'h00, 1);
      wt(8);
      chk({6'h00, p1, p0}, 8'h00);
      rd(8'h00, 1);
      chk(b0, `SCIP_OUT_EN_RSVD);
      $display("test clear enables done");
      wr(1'b0, P1, P0, 2);
      wt(8);
      chk({6'h00, p1, p0}, 8'h02);
      rd(8'h01, 1);
      chk(b0, `SCIP_UNMAPPED_RD);
      rd(8'h00, 1);
      chk(b0, `SCIP_OUT_EN_RSVD | P1);
      wr(1'b0, P0, 8'h00, 1);
      wt(8);
      chk({6'h00, p1, p0}, 8'h01);
      $display("test block write done");
      dev = `SCIP_ADDR_SEL1;
      wr(1'b1, 8'hff, 8'h00, 1);
      chk({6'h00, p1, p0}, 8'h01);
      dev = `SCIP_ADDR_SEL0;
      strap = 1'b1;
      rd(8'h00, 1);
      rst_n = 1'b0;
      wt(2);
      rst_n = 1'b1;
      wt(60);
      dev = `SCIP_ADDR_SEL1;
      rd(8'h00, 1);
      chk(b0, `SCIP_OUT_EN_RST);
      hw0_n = 1'b1;
      hw1_n = 1'b1;
      wt(8);
      chk({6'h00, p1, p0}, 8'h00);
      hw0_n = 1'b0;
      hw1_n = 1'b0;
      $display("test address and pins done");
      ref_en = 1'b0;
      wt(`SCIP_REF_LOSS_CYC + 20);
      chk({7'h00, ref_ok}, 8'h00);
      wr(1'b1, 8'h00, 8'h00, 1);
      ref_en = 1'b1;
      wt(60);
      rd(8'h00, 1);
      chk(b0, `SCIP_OUT_EN_RST);
      $display("test reference loss done");
      end_sim();
   end
endmodule // scip_smbus_port_tb_top
`default_nettype wire
